// [design/aacx_defs.vh]
// Constants for the add, and, call and clear execution block
`ifndef AACX_DEFS_VH
`define AACX_DEFS_VH

// Operation codes (3 bits)
`define AACX_OP_NONE 3'h0
`define AACX_OP_ADD 3'h1
`define AACX_OP_AND 3'h2
`define AACX_OP_CALL 3'h3
`define AACX_OP_CLR 3'h4

// Flag bit positions in the status vector
`define AACX_FLG_C 0
`define AACX_FLG_AC 1
`define AACX_FLG_Z 2
`define AACX_FLG_OV 3

// Reset values
`define AACX_WREG_RST 8'h00
`define AACX_FLAGS_RST 4'h0
`define AACX_PC_RST 12'h000
`define AACX_CLR_VAL 8'h00

// Machine cycles of a call
`define AACX_CALL_CYCLES 2

`endif

// [design/aacx_exec.v]
// Execution datapath for addition, AND, call and clear-memory operations
`timescale 1ns/100ps
// Summary of operation
// - Add with carry, result to working register
// - Add with carry, result to memory byte
// - Add memory operand without carry, into register
// - Add immediate without carry, into register
// - Add without carry, result to memory byte
// - AND memory into register, only zero flag
// - AND immediate into register, only zero flag
// - AND result to memory, only zero flag
// - Call pushes next address, loads target
// - Call takes two cycles, flags unchanged
// - Clear writes zero to byte, flags unchanged
`include "aacx_defs.vh"

module aacx_exec #(
	parameter DW = 8,
	parameter PCW = 12
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_valid,
	input wire [2:0] i_op,
	input wire i_use_carry,
	input wire i_use_imm,
	input wire i_to_mem,
	input wire [DW-1:0] i_imm,
	input wire [DW-1:0] i_mem_rdata,
	input wire [PCW-1:0] i_pc,
	input wire [PCW-1:0] i_target,
	output wire o_busy,
	output wire o_done,
	output reg o_mem_we,
	output reg [DW-1:0] o_mem_wdata,
	output reg o_push,
	output reg [PCW-1:0] o_push_data,
	output reg o_pc_load,
	output reg [PCW-1:0] o_pc_next,
	output wire [DW-1:0] o_working_register,
	output wire o_carry_flag,
	output wire o_half_out_flag,
	output wire o_zero_flag,
	output wire o_signed_wrap_flag
);

////////////////////////////////////////////////////////////////////////////////
// State codes for the two-cycle call
localparam ST_IDLE = 2'h1;
localparam ST_CALL2 = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// State and next values
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [DW-1:0] working_register_r;
reg [DW-1:0] working_register_nxt;
reg [3:0] flags_r;
reg [3:0] flags_nxt;
reg [PCW-1:0] target_r;
reg [PCW-1:0] target_nxt;
reg done_r;
reg done_nxt;
reg mem_we_nxt;
reg [DW-1:0] mem_wdata_nxt;
reg push_nxt;
reg [PCW-1:0] push_data_nxt;
reg pc_load_nxt;
reg [PCW-1:0] pc_next_nxt;

////////////////////////////////////////////////////////////////////////////////
// Request decode
wire start;
wire in_call2;
wire is_add;
wire is_and;
wire is_call;
wire is_clr;
wire is_alu;
wire alu_to_mem;
wire alu_to_reg;

assign in_call2 = (state_r == ST_CALL2);
assign start = i_valid && (state_r == ST_IDLE);
assign is_add = start && (i_op == `AACX_OP_ADD);
assign is_and = start && (i_op == `AACX_OP_AND);
assign is_call = start && (i_op == `AACX_OP_CALL);
assign is_clr = start && (i_op == `AACX_OP_CLR);
assign is_alu = is_add || is_and;
assign alu_to_mem = is_alu && i_to_mem;
assign alu_to_reg = is_alu && !i_to_mem;

////////////////////////////////////////////////////////////////////////////////
// Operand select
wire [DW-1:0] operand;
wire carry_in;

assign operand = i_use_imm ? i_imm : i_mem_rdata;
assign carry_in = i_use_carry & flags_r[`AACX_FLG_C];

////////////////////////////////////////////////////////////////////////////////
// Ripple adder and bitwise AND, one slice per bit
wire [DW:0] carry_chain;
wire [DW-1:0] sum;
wire [DW-1:0] band;

assign carry_chain[0] = carry_in;

genvar gi;
generate
	for (gi = 0; gi < DW; gi = gi + 1) begin : g_bit
		wire a_bit;
		wire b_bit;
		wire prop_bit;
		wire gen_bit;
		assign a_bit = working_register_r[gi];
		assign b_bit = operand[gi];
		assign prop_bit = a_bit ^ b_bit;
		assign gen_bit = a_bit & b_bit;
		assign sum[gi] = prop_bit ^ carry_chain[gi];
		assign carry_chain[gi+1] = gen_bit | (carry_chain[gi] & prop_bit);
		assign band[gi] = gen_bit;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Flag terms
wire add_carry;
wire add_half;
wire add_zero;
wire add_ovf;
wire and_zero;

assign add_carry = carry_chain[DW];
assign add_half = carry_chain[4];
assign add_zero = (sum == {DW{1'h0}});
assign add_ovf = carry_chain[DW] ^ carry_chain[DW-1];
assign and_zero = (band == {DW{1'h0}});

////////////////////////////////////////////////////////////////////////////////
// Call sequencing
always @* begin
	state_nxt = state_r;
	case (state_r)
		ST_IDLE: begin
			if (is_call) begin
				state_nxt = ST_CALL2;
			end
		end
		ST_CALL2: begin
			state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Working register
always @* begin
	working_register_nxt = working_register_r;
	if (alu_to_reg) begin
		if (is_add) begin
			working_register_nxt = sum;
		end else begin
			working_register_nxt = band;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status flags, kept by call and clear
always @* begin
	flags_nxt = flags_r;
	if (is_add) begin
		flags_nxt[`AACX_FLG_C] = add_carry;
		flags_nxt[`AACX_FLG_AC] = add_half;
		flags_nxt[`AACX_FLG_Z] = add_zero;
		flags_nxt[`AACX_FLG_OV] = add_ovf;
	end else if (is_and) begin
		flags_nxt[`AACX_FLG_Z] = and_zero;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Data memory write-back
always @* begin
	mem_we_nxt = 1'h0;
	mem_wdata_nxt = o_mem_wdata;
	if (alu_to_mem) begin
		mem_we_nxt = 1'h1;
		if (is_add) begin
			mem_wdata_nxt = sum;
		end else begin
			mem_wdata_nxt = band;
		end
	end else if (is_clr) begin
		mem_we_nxt = 1'h1;
		mem_wdata_nxt = `AACX_CLR_VAL;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Return address push and program counter load
always @* begin
	push_nxt = 1'h0;
	push_data_nxt = o_push_data;
	target_nxt = target_r;
	if (is_call) begin
		push_nxt = 1'h1;
		push_data_nxt = i_pc + {{(PCW-1){1'h0}}, 1'h1};
		target_nxt = i_target;
	end
end

always @* begin
	pc_load_nxt = 1'h0;
	pc_next_nxt = o_pc_next;
	if (in_call2) begin
		pc_load_nxt = 1'h1;
		pc_next_nxt = target_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Completion pulse
always @* begin
	done_nxt = 1'h0;
	if (in_call2) begin
		done_nxt = 1'h1;
	end else if (start) begin
		case (i_op)
			`AACX_OP_CALL: begin
				done_nxt = 1'h0;
			end
			default: begin
				done_nxt = 1'h1;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer and status registers
always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		state_r <= ST_IDLE;
		done_r <= 1'h0;
		target_r <= `AACX_PC_RST;
	end else begin
		state_r <= state_nxt;
		done_r <= done_nxt;
		target_r <= target_nxt;
	end
end

always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		working_register_r <= `AACX_WREG_RST;
		flags_r <= `AACX_FLAGS_RST;
	end else begin
		working_register_r <= working_register_nxt;
		flags_r <= flags_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs towards memory, stack and program counter
always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		o_mem_we <= 1'h0;
		o_mem_wdata <= `AACX_CLR_VAL;
	end else begin
		o_mem_we <= mem_we_nxt;
		o_mem_wdata <= mem_wdata_nxt;
	end
end

always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		o_push <= 1'h0;
		o_push_data <= `AACX_PC_RST;
		o_pc_load <= 1'h0;
		o_pc_next <= `AACX_PC_RST;
	end else begin
		o_push <= push_nxt;
		o_push_data <= push_data_nxt;
		o_pc_load <= pc_load_nxt;
		o_pc_next <= pc_next_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Output wiring
assign o_busy = in_call2;
assign o_done = done_r;
assign o_working_register = working_register_r;
assign o_carry_flag = flags_r[`AACX_FLG_C];
assign o_half_out_flag = flags_r[`AACX_FLG_AC];
assign o_zero_flag = flags_r[`AACX_FLG_Z];
assign o_signed_wrap_flag = flags_r[`AACX_FLG_OV];

endmodule // aacx_exec

// [testbench/aacx_exec_assertions.sv]
// Execution block assertions
`timescale 1ns/100ps
module aacx_exec_chk(input wire i_clk, i_rst, i_valid, i_to_mem, o_busy, o_done,
	o_mem_we, o_push, o_pc_load, o_carry_flag, o_zero_flag, input wire [2:0] i_op);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
wire g = i_valid && !o_busy;
sequence cs; g && i_op == 3'h3; endsequence
sequence ld_s; !o_done ##1 o_pc_load && o_done && !o_busy; endsequence
call_push_a: assert property (cs |=> o_push && o_busy) else $error("push");
call_load_a: assert property (cs |=> ld_s) else $error("load");
call_flag_a: assert property (cs |=> $stable(o_carry_flag) [*2]) else $error("cf");
busy_once_a: assert property (o_busy |=> !o_busy) else $error("busy");
clr_flag_a: assert property (g && i_op == 3'h4 |=>
	$stable(o_zero_flag) && o_mem_we) else $error("clr");
and_flag_a: assert property (g && i_op == 3'h2 |=> $stable(o_carry_flag)) else $error("and");
add_done_a: assert property (g && i_op == 3'h1 |=> o_done) else $error("add");
mem_sel_a: assert property (g && i_op == 3'h1 |=>
	o_mem_we == $past(i_to_mem)) else $error("we");
endmodule // aacx_exec_chk
bind aacx_exec aacx_exec_chk aacx_exec_chk_i(.*);

// [testbench/tb_top.sv]
// Random bench for the execution block
`timescale 1ns/100ps
module tb_top;
reg i_clk = 0, i_rst = 1, i_valid = 0, i_use_carry = 0, i_use_imm = 0, i_to_mem = 0;
reg [3:0] f = 0;
reg [2:0] i_op = 0;
reg [7:0] i_imm = 0, i_mem_rdata = 0, w = 0, md = 0, b, r;
reg [11:0] i_pc = 0, i_target = 0, pn = 0, pd = 0;
reg [15:0] q = 16'h0011;
reg [8:0] s;
reg we, alu;
wire o_busy, o_done, o_mem_we, o_push, o_pc_load, o_carry_flag;
wire o_half_out_flag, o_zero_flag, o_signed_wrap_flag;
wire [7:0] o_mem_wdata, o_working_register;
wire [11:0] o_push_data, o_pc_next;
integer err_total = 0, n_checks = 0;
aacx_exec aacx_exec_i(.*);
initial forever #25 i_clk = ~i_clk;
function [15:0] nx(input [15:0] v);
	nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task chk(input [31:0] g, e);
	begin
		n_checks = n_checks + 1;
		err_total = err_total + (g !== e);
		if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
	end
endtask
task wrap_up;
	begin
		$display("%0d checks %0d errors", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end
endtask
task run;
	begin
		@(posedge i_clk) #1;
		q = nx(q);
		{i_use_carry, i_use_imm, i_to_mem, i_valid} = {q[2:0], 1'h1};
		i_op = (q[7:5] == 3'h0) ? q[10:8] : 3'h1 + q[4:3];
		{i_imm, i_mem_rdata, i_pc, i_target} = {q, q[11:0], q[15:4]};
		alu = i_op == 3'h1 || i_op == 3'h2;
		b = i_use_imm ? i_imm : i_mem_rdata;
		s = w + b + (i_use_carry & f[3]);
		r = i_op == 3'h1 ? s[7:0] : w & b;
		we = i_op == 3'h4 || i_to_mem && alu;
		if (i_op == 3'h1) {f[3], f[2], f[0]} = {s[8], w[4] ^ b[4] ^ s[4], w[7] == b[7] && s[7] != w[7]};
		if (alu) f[1] = !r;
		if (we) md = i_op == 3'h4 ? 8'h00 : r;
		else if (alu) w = r;
		if (i_op == 3'h3) {pn, pd} = {i_target, i_pc + 12'h001};
		@(posedge i_clk) #1;
		chk({o_push, o_busy, o_pc_load}, {i_op == 3'h3, i_op == 3'h3, 1'h0});
		if (i_op == 3'h3) begin
			chk({o_done, o_mem_we}, 2'h0);
			@(posedge i_clk) #1;
			chk({o_push, o_busy, o_pc_load}, 3'h1);
		end
		chk({o_pc_next, o_push_data}, {pn, pd});
		chk({o_done, o_mem_we, o_mem_wdata, o_working_register, o_carry_flag, o_half_out_flag,
			o_zero_flag, o_signed_wrap_flag}, {1'h1, we, md, w, f});
		i_valid = 0;
	end
endtask
initial begin
	repeat (16) @(posedge i_clk);
	#1 i_rst = 0;
	repeat (400) run;
	wrap_up;
end
initial begin
	repeat (2000) @(posedge i_clk);
	err_total = err_total + 1;
	wrap_up;
end
endmodule // tb_top
